// ### hdl/ppsm_pkg.sv
// Package for the physical-layer power-state manager.
// Assumes a single 25 MHz clock; all counts are derived from it here.
package ppsm_pkg;

	localparam int unsigned CLK_HZ        = 25_000_000;
	// Break-link wait: at least 1.2 s, at most 1.3 s
	localparam int unsigned BRK_MIN_MS    = 1200;
	localparam int unsigned BRK_MAX_MS    = 1300;
	localparam int unsigned BRK_MS        = 1250;
	localparam int unsigned BRK_CYC       = (CLK_HZ / 1000) * BRK_MS;
	localparam int unsigned BRK_MIN_CYC   = (CLK_HZ / 1000) * BRK_MIN_MS;
	localparam int unsigned BRK_MAX_CYC   = (CLK_HZ / 1000) * BRK_MAX_MS;
	// Power-down bit position in the PHY control register
	localparam int unsigned PWRDN_BIT     = 11;
	// Power-down response encodings
	localparam logic        PDR_STAY      = 1'b0;
	localparam logic        PDR_DOWN      = 1'b1;
	localparam int unsigned CNT_W         = 26;
	localparam logic [25:0] CNT_RST       = 26'h000_0000;

	typedef enum logic [7:0] {
		PS_POWER_UP  = 8'b0000_0001,
		PS_ACTIVE    = 8'b0000_0010,
		PS_IDLE      = 8'b0000_0100,
		PS_CABLE_OFF = 8'b0000_1000,
		PS_IEEE_PD   = 8'b0001_0000,
		PS_LAN_PD    = 8'b0010_0000,
		PS_LINK_INIT = 8'b0100_0000,
		PS_AN_WAIT   = 8'b1000_0000
	} ppsm_state_t;

endpackage : ppsm_pkg

// ### hdl/ppsm_top.sv
// Global power-state manager of an Ethernet physical-layer device.
// Assumes: single mclk domain, in-band messages arrive as one-cycle
// pulses or levels from same-clock logic, pins are asynchronous.
`timescale 1ns/10ps

module ppsm_top
	import ppsm_pkg::*;
#(
	parameter int unsigned BRK_WAIT_CYC = BRK_CYC
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rstn,
	// Device pins, asynchronous
	input  wire logic lan_off_pin_n,
	input  wire logic lan_supply_ok_n,
	// Ethernet link status from the physical layer
	input  wire logic cable_present,
	input  wire logic energy_detect,
	input  wire logic link_up,
	input  wire logic link_busy,
	input  wire logic partner_tx_lpi,
	// Controller in-band messages and configuration
	input  wire logic ib_power_down,
	input  wire logic ib_power_up,
	input  wire logic ib_tx_lpi_req,
	input  wire logic lpi_enable,
	input  wire logic phy_ctrl_pwrdn,
	input  wire logic pd_response,
	input  wire logic config_done,
	input  wire logic link_init_done,
	// Status and power controls
	output logic      [7:0] power_state,
	output logic            ib_link_down,
	output logic            cable_absent_flag,
	output logic            ib_rx_lpi_ind,
	output logic            rx_power_off,
	output logic            tx_lpi_active,
	output logic            phy_powered_down,
	output logic            phy_energy_detect_mode,
	output logic            clocks_gated,
	output logic            pcie_elec_idle,
	output logic            if_reset,
	output logic            an_start,
	output logic            an_enable,
	output logic            partial_power_down
);

	typedef struct packed {
		logic        off_s1;
		logic        off_s2;
		logic        sup_s1;
		logic        sup_s2;
		ppsm_state_t st;
		logic [CNT_W-1:0] cnt;
		logic        ib_pd;
		logic        rx_lpi;
		logic        tx_lpi;
		logic        cab_abs;
		logic        an_go;
	} ppsm_reg_t;

	ppsm_reg_t r;
	ppsm_reg_t next_r;

	logic pin_off;
	logic sup_bad;
	logic pd_cmd;

	always_comb begin
		pin_off = !r.off_s2;
		sup_bad = r.sup_s2;
		// Response field decides whether a command powers anything down
		pd_cmd  = (pd_response == PDR_DOWN);
	end

	always_comb begin
		next_r        = r;
		next_r.off_s1 = lan_off_pin_n;
		next_r.off_s2 = r.off_s1;
		next_r.sup_s1 = lan_supply_ok_n;
		next_r.sup_s2 = r.sup_s1;
		next_r.an_go  = 1'b0;
		if (!lpi_enable || !link_up) begin
			next_r.rx_lpi = 1'b0;
			next_r.tx_lpi = 1'b0;
		end else begin
			next_r.rx_lpi = partner_tx_lpi;
			next_r.tx_lpi = ib_tx_lpi_req;
		end
		// Pin and supply take priority over every other request
		if ((pin_off || sup_bad) && pd_cmd) begin
			next_r.st     = PS_LAN_PD;
			next_r.ib_pd  = 1'b0;
			next_r.rx_lpi = 1'b0;
			next_r.tx_lpi = 1'b0;
		end else if (ib_power_down && pd_cmd
			&& r.st != PS_LAN_PD) begin
			next_r.st     = PS_LAN_PD;
			next_r.ib_pd  = 1'b1;
			next_r.rx_lpi = 1'b0;
			next_r.tx_lpi = 1'b0;
		end else begin
			unique case (r.st)
			PS_POWER_UP: begin
				next_r.st = PS_LINK_INIT;
			end
			PS_ACTIVE, PS_IDLE: begin
				if (phy_ctrl_pwrdn && pd_cmd) begin
					next_r.st = PS_IEEE_PD;
				end else if (!cable_present) begin
					next_r.st      = PS_CABLE_OFF;
					next_r.cab_abs = 1'b1;
				end else if (!link_up) begin
					next_r.st = PS_AN_WAIT;
					next_r.cnt = CNT_RST;
				end else begin
					next_r.st = link_busy ? PS_ACTIVE : PS_IDLE;
				end
			end
			PS_CABLE_OFF: begin
				if (energy_detect) begin
					next_r.st      = PS_AN_WAIT;
					next_r.cab_abs = 1'b0;
					next_r.cnt     = CNT_RST;
				end
			end
			PS_IEEE_PD: begin
				if (!phy_ctrl_pwrdn || !pd_cmd) begin
					next_r.st  = PS_AN_WAIT;
					next_r.cnt = CNT_RST;
				end
			end
			PS_LAN_PD: begin
				// In-band exits only the in-band power-down
				if ((!r.ib_pd && !pin_off && !sup_bad)
					|| (r.ib_pd && ib_power_up)
					|| !pd_cmd) begin
					next_r.st    = PS_LINK_INIT;
					next_r.ib_pd = 1'b0;
				end
			end
			PS_LINK_INIT: begin
				// Configuration only counts once link_init_done is also high
				if (link_init_done && config_done) begin
					next_r.st  = PS_AN_WAIT;
					next_r.cnt = CNT_RST;
				end
			end
			PS_AN_WAIT: begin
				if (!cable_present) begin
					next_r.st      = PS_CABLE_OFF;
					next_r.cab_abs = 1'b1;
				end else if (r.cnt >= CNT_W'(BRK_WAIT_CYC - 1)) begin
					next_r.an_go = 1'b1;
					next_r.st    = PS_IDLE;
				end else begin
					next_r.cnt = r.cnt + CNT_W'(1);
				end
			end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			r         <= '0;
			r.off_s1  <= 1'b1;
			r.off_s2  <= 1'b1;
			r.st      <= PS_POWER_UP;
			r.cnt     <= CNT_RST;
		end else begin
			r <= next_r;
		end
	end

	always_comb begin
		power_state            = r.st;
		ib_link_down           = r.cab_abs || !link_up;
		cable_absent_flag      = r.cab_abs;
		ib_rx_lpi_ind          = r.rx_lpi;
		rx_power_off           = r.rx_lpi;
		tx_lpi_active          = r.tx_lpi;
		phy_powered_down       = (r.st == PS_LAN_PD)
			|| (r.st == PS_IEEE_PD);
		phy_energy_detect_mode = (r.st == PS_CABLE_OFF);
		// Clock gating is not possible when only in-band logic sleeps
		clocks_gated           = (r.st == PS_LAN_PD) && !r.ib_pd;
		partial_power_down     = (r.st == PS_LAN_PD) && r.ib_pd;
		pcie_elec_idle         = phy_powered_down
			|| (r.st == PS_CABLE_OFF);
		if_reset               = (r.st == PS_LAN_PD)
			|| (r.st == PS_POWER_UP);
		an_start               = r.an_go;
		an_enable              = (r.st == PS_ACTIVE) || (r.st == PS_IDLE);
	end

endmodule : ppsm_top

// ### tb/ppsm_ctrl_model.sv
// LAN controller model: brings the link up, then configures.
// Assumes it runs from the device's mclk.
`timescale 1ns/10ps
module ppsm_ctrl_model #(parameter int DLY = 3) (
	input wire logic mclk, rstn,
	input wire logic [7:0] power_state,
	output logic link_init_done, config_done
);
	int cnt;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn || power_state != 8'h40) cnt <= 0;
		else cnt <= cnt + 1;
	end
	assign link_init_done = cnt > DLY;
	// Configuration only after init, far inside the deadline
	assign config_done = cnt > 2 * DLY;
endmodule : ppsm_ctrl_model

// ### tb/ppsm_monitor.sv
// Checker for the power-state manager, bound into ppsm_top.
// Assumes one mclk domain; the wait count comes from the top.
`timescale 1ns/10ps
module ppsm_monitor
	import ppsm_pkg::*;
#(parameter int unsigned BRK_WAIT_CYC = 20) (
	// Clock, reset and inputs
	input wire logic mclk, rstn, lan_off_pin_n, lan_supply_ok_n,
	input wire logic energy_detect, link_up, ib_power_down, lpi_enable,
	input wire logic pd_response,
	// Outputs
	input wire logic [7:0] power_state,
	input wire logic ib_link_down, cable_absent_flag, ib_rx_lpi_ind,
	input wire logic rx_power_off, tx_lpi_active, pcie_elec_idle,
	input wire logic if_reset, an_start
);
	logic [31:0] brk_cnt;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) brk_cnt <= '0;
		else if (power_state == 8'h80) brk_cnt <= brk_cnt + 1;
		else brk_cnt <= '0;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// Three samples: two sync stages, then the state register
	sequence pin_low_s; (!lan_off_pin_n && pd_response) [*3]; endsequence
	sequence pins_ok_s; (lan_off_pin_n && !lan_supply_ok_n) [*3]; endsequence
	pin_pd_a: assert property (
		pin_low_s ##1 (!lan_off_pin_n && pd_response) |-> power_state == 8'h20)
		else $error("pin power-down missed");
	pd_out_a: assert property (
		power_state == 8'h20 |-> pcie_elec_idle && if_reset)
		else $error("power-down outputs wrong");
	link_down_a: assert property (
		ib_link_down == (cable_absent_flag || !link_up))
		else $error("link-down report wrong");
	reconnect_a: assert property (
		pins_ok_s ##0 (power_state == 8'h08 && energy_detect && !ib_power_down)
		|=> power_state == 8'h80 && !cable_absent_flag)
		else $error("reconnect exit wrong");
	brk_win_a: assert property (
		an_start |-> brk_cnt + 2 >= BRK_WAIT_CYC && brk_cnt <= BRK_WAIT_CYC + 2)
		else $error("break-link wait wrong");
	an_pulse_a: assert property (an_start |=> !an_start)
		else $error("negotiation start too long");
	lpi_off_a: assert property (
		!lpi_enable [*2] |-> !ib_rx_lpi_ind && !rx_power_off && !tx_lpi_active)
		else $error("idle flags while disabled");
	stay_on_a: assert property (
		!pd_response [*8] |-> power_state != 8'h20 && power_state != 8'h10)
		else $error("power-down in stay-active mode");
endmodule : ppsm_monitor
bind ppsm_top ppsm_monitor #(.BRK_WAIT_CYC(BRK_WAIT_CYC)) i_mon (.*);

// ### tb/tb_top.sv
// Bench: table walk of the power states, then LPI and reset.
// Assumes the break-link wait is cut to 20 cycles.
`timescale 1ns/10ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
	fail_count++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb_top;
	logic mclk = 0, rstn = 0, lan_off_pin_n = 1, lan_supply_ok_n = 0;
	logic cable_present = 1, energy_detect = 1, link_up = 0, link_busy = 0;
	logic partner_tx_lpi = 0, ib_power_down = 0, ib_power_up = 0;
	logic ib_tx_lpi_req = 0, lpi_enable = 0, phy_ctrl_pwrdn = 0;
	logic pd_response = 1, config_done, link_init_done, ib_link_down;
	logic [7:0] power_state;
	logic cable_absent_flag, ib_rx_lpi_ind, rx_power_off, tx_lpi_active;
	logic phy_powered_down, phy_energy_detect_mode, clocks_gated, if_reset;
	logic pcie_elec_idle, an_start, an_enable, partial_power_down;
	int fail_count = 0, num_checks = 0, k;
	logic [7:0] exp_st;
	logic ib_row;
	// {pdr,pin,supply,ib_pd,ib_pu,ctrl_pd,cable,energy,link,busy}, state
	logic [17:0] rows [14] = '{18'h3_0e04, 18'h3_0f02, 18'h3_0008,
		18'h3_0f02, 18'h3_1f10, 18'h3_0f02, 18'h3_4f20, 18'h3_2f02,
		18'h2_0f20, 18'h3_0f02, 18'h3_8f20, 18'h3_0f02, 18'h0_0f02,
		18'h3_0f02};
	always #20 mclk = ~mclk;
	ppsm_top #(.BRK_WAIT_CYC(20)) i_dut (.*);
	ppsm_ctrl_model #(.DLY(3)) i_ctrl (.*);
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	// The fixed pause lets a refused command show that nothing moved
	task automatic settle(input logic [7:0] e);
		repeat (8) @(posedge mclk);
		for (k = 0; k < 200 && power_state !== e; k++) @(negedge mclk);
	endtask : settle
	initial begin
		repeat (4000) @(posedge mclk);
		fail_count++;
		stop_test();
	end
	initial begin
		repeat (2) @(posedge mclk);
		rstn <= 1;
		foreach (rows[i]) begin
			@(posedge mclk);
			// Power-down bit only moves after configuration has finished
			{pd_response, lan_off_pin_n, lan_supply_ok_n, ib_power_down,
				ib_power_up, phy_ctrl_pwrdn, cable_present, energy_detect,
				link_up, link_busy} <= rows[i][17:8];
			@(posedge mclk);
			ib_power_down <= 0;
			ib_power_up <= 0;
			settle(rows[i][7:0]);
			`CHK("st", rows[i][7:0], power_state)
			exp_st = rows[i][7:0];
			ib_row = rows[i][14];
			`CHK("dec", {exp_st == 8'h20 || exp_st == 8'h10, exp_st == 8'h08, exp_st == 8'h20 && !ib_row, exp_st == 8'h20 && ib_row, exp_st == 8'h02 || exp_st == 8'h04, exp_st == 8'h08, exp_st == 8'h20 || exp_st == 8'h10 || exp_st == 8'h08, exp_st == 8'h20}, {phy_powered_down, phy_energy_detect_mode, clocks_gated, partial_power_down, an_enable, cable_absent_flag, pcie_elec_idle, if_reset})
		end
		@(posedge mclk);
		lpi_enable <= 1;
		partner_tx_lpi <= 1;
		ib_tx_lpi_req <= 1;
		repeat (4) @(negedge mclk);
		`CHK("lpi", 3'h7, {ib_rx_lpi_ind, rx_power_off, tx_lpi_active})
		@(posedge mclk);
		lpi_enable <= 0;
		repeat (3) @(negedge mclk);
		`CHK("lpi", 3'h0, {ib_rx_lpi_ind, rx_power_off, tx_lpi_active})
		@(posedge mclk);
		rstn <= 0;
		@(negedge mclk);
		`CHK("rst", 9'h003, {power_state, if_reset})
		@(posedge mclk);
		rstn <= 1;
		repeat (2) @(negedge mclk);
		`CHK("init", 8'h40, power_state)
		settle(8'h02);
		`CHK("st", 8'h02, power_state)
		stop_test();
	end
endmodule : tb_top
